// ### dv/aux_equipment_model.sv
// Model of the outside equipment driving the isolated inputs
`timescale 1ns/1ps
`default_nettype none
module aux_equipment_model (
    input  wire logic       aclk,
    input  wire logic       job_paused,
    input  wire logic [2:0] release_sel,
    input  wire logic [7:0] release_delay,
    input  wire logic       abort_req,
    input  wire logic       reset_req,
    output logic            iso_trigger_input,
    output logic            iso_wait_input_1,
    output logic            iso_wait_input_2,
    output logic            iso_wait_input_3,
    output logic            iso_wait_input_4,
    output logic            iso_reset_request_n,
    output logic            iso_abort_input
);
    logic [7:0] count = 8'h00;
    logic [4:0] lines = 5'h00;
    // Release comes only after the set delay, so slow equipment is covered too
    always @(posedge aclk) begin
        if (!job_paused) begin
            count <= 8'h00;
            lines <= 5'h00;
        end else if (count >= release_delay) begin
            lines <= 5'h01 << release_sel;
        end else begin
            count <= count + 8'h01;
        end
    end
    assign {iso_wait_input_4, iso_wait_input_3, iso_wait_input_2, iso_wait_input_1, iso_trigger_input} = lines;
    assign iso_abort_input = abort_req;
    assign iso_reset_request_n = !reset_req;
endmodule
`default_nettype wire

// ### dv/aux_job_io_control_asserts.sv
// Concurrent checks on the auxiliary job-control I/O ports
`timescale 1ns/1ps
`default_nettype none
module aux_job_io_control_asserts (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic iso_abort_input,
    input wire logic iso_reset_request_n,
    input wire logic job_open_instr,
    input wire logic job_close_instr,
    input wire logic hw_exception,
    input wire logic soft_reset_out,
    input wire logic error_ready_out,
    input wire logic job_pending_out,
    input wire logic job_in_execution_out,
    input wire logic marking_in_progress_out,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_arready
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Three samples cover the two synchroniser stages
    sequence abort_held;
        iso_abort_input [*3];
    endsequence
    sequence reset_held;
        !iso_reset_request_n [*3];
    endsequence
    sequence job_start;
        job_open_instr && !job_close_instr && !iso_abort_input && iso_reset_request_n && !soft_reset_out;
    endsequence
    open_sets_pending_a: assert property (job_start |-> ##[1:3] job_pending_out)
        else $error("job pending did not rise after open");
    close_ends_job_a: assert property (job_close_instr && !job_open_instr |-> ##[1:3]
        !job_in_execution_out && !marking_in_progress_out)
        else $error("job close left execution or marking up");
    open_sets_exec_a: assert property (job_start |-> ##1 job_in_execution_out)
        else $error("execution did not rise after open");
    marking_in_job_a: assert property (marking_in_progress_out |-> job_pending_out)
        else $error("marking outside an active job");
    abort_to_idle_a: assert property (abort_held |-> ##[1:3]
        !job_pending_out && !marking_in_progress_out)
        else $error("abort did not return job to idle");
    soft_reset_entry_a: assert property (reset_held |-> ##[1:4] soft_reset_out && error_ready_out)
        else $error("reset request did not start soft reset");
    exception_error_a: assert property (hw_exception |-> ##[1:3] error_ready_out)
        else $error("exception did not raise error output");
    boot_not_ready_a: assert property ($rose(aresetn) |-> error_ready_out [*8])
        else $error("error output low right after reset");
    write_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted while response pending");
    read_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while data pending");
endmodule
bind aux_job_io_control aux_job_io_control_asserts u_asserts (.aclk, .aresetn, .iso_abort_input,
    .iso_reset_request_n, .job_open_instr, .job_close_instr, .hw_exception, .soft_reset_out,
    .error_ready_out, .job_pending_out, .job_in_execution_out, .marking_in_progress_out,
    .s_axi_bvalid, .s_axi_awready, .s_axi_wready, .s_axi_rvalid, .s_axi_arready);
`default_nettype wire

// ### dv/aux_job_io_control_tb.sv
// Self-checking bench for the auxiliary job-control I/O block
`timescale 1ns/1ps
`default_nettype none
module aux_job_io_control_tb import aux_job_pkg::*; ;
    logic aclk, aresetn, job_open_instr, job_close_instr, wait_trigger_instr, wait_input_instr;
    logic marking_start, set_outputs_instr, hw_exception, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_rready, abort_req, reset_req;
    logic [1:0] wait_input_select, rsp;
    logic [3:0] set_outputs_value, s_axi_wstrb;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, rd;
    logic [2:0] release_sel;
    logic [7:0] release_delay;
    wire logic iso_trigger_input, iso_wait_input_1, iso_wait_input_2, iso_wait_input_3, iso_wait_input_4;
    wire logic iso_reset_request_n, iso_abort_input, job_paused, job_aborted, soft_reset_out, error_ready_out;
    wire logic job_pending_out, job_in_execution_out, marking_in_progress_out, irq;
    wire logic job_output_1, job_output_2, job_output_3, job_output_4;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp;
    wire logic [31:0] s_axi_rdata;
    int n_fail, tests_run, cyc;
    // Row: wait select (0 trigger, 1..4 inputs), output value, release delay
    localparam logic [15:0] ROWS [5] = '{16'h0500, 16'h1A14, 16'h2300, 16'h3C14, 16'h4F00};

    aux_job_io_control u_dut (.aclk, .aresetn, .iso_trigger_input, .iso_wait_input_1, .iso_wait_input_2,
        .iso_wait_input_3, .iso_wait_input_4, .iso_reset_request_n, .iso_abort_input, .job_open_instr,
        .job_close_instr, .wait_trigger_instr, .wait_input_instr, .wait_input_select, .marking_start,
        .set_outputs_instr, .set_outputs_value, .hw_exception, .job_paused, .job_aborted, .soft_reset_out,
        .error_ready_out, .job_pending_out, .job_in_execution_out, .marking_in_progress_out, .job_output_1,
        .job_output_2, .job_output_3, .job_output_4, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    aux_equipment_model u_equip (.aclk, .job_paused, .release_sel, .release_delay, .abort_req, .reset_req,
        .iso_trigger_input, .iso_wait_input_1, .iso_wait_input_2, .iso_wait_input_3, .iso_wait_input_4,
        .iso_reset_request_n, .iso_abort_input);

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done;
        if (n_fail == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    // One-cycle sequencer event
    task automatic pulse(input int k);
        case (k)
            0: job_open_instr <= 1'b1;
            1: job_close_instr <= 1'b1;
            2: wait_trigger_instr <= 1'b1;
            3: wait_input_instr <= 1'b1;
            4: marking_start <= 1'b1;
            5: set_outputs_instr <= 1'b1;
            default: hw_exception <= 1'b1;
        endcase
        @(posedge aclk);
        {job_open_instr, job_close_instr, wait_trigger_instr, wait_input_instr} <= 4'h0;
        {marking_start, set_outputs_instr, hw_exception} <= 3'h0;
    endtask
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // A hang ends the run as a failure
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            test_done;
        end
    end

    initial begin
        logic [2:0] sel;
        logic [3:0] v;
        logic [7:0] dly;
        {aresetn, job_open_instr, job_close_instr, wait_trigger_instr, wait_input_instr} = 5'h00;
        {marking_start, set_outputs_instr, hw_exception, abort_req, reset_req} = 5'h00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {wait_input_select, set_outputs_value, s_axi_wstrb, release_sel, release_delay} = 21'h07800;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        {n_fail, tests_run, cyc} = 96'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        tick(1);
        check("error_ready", 1, error_ready_out);
        tick(BOOT_CYCLES - 10);
        check("error_ready", 1, error_ready_out);
        tick(15);
        check("error_ready", 0, error_ready_out);
        for (int i = 0; i < 5; i++) begin
            {sel, v, dly} = {ROWS[i][14:12], ROWS[i][11:8], ROWS[i][7:0]};
            release_sel <= sel;
            release_delay <= dly;
            pulse(0);
            tick(3);
            check("execution", 1, job_in_execution_out);
            set_outputs_value <= v;
            pulse(5);
            tick(3);
            check("outputs", v, {job_output_4, job_output_3, job_output_2, job_output_1});
            wait_input_select <= 2'(sel - 3'h1);
            pulse(sel == 3'h0 ? 2 : 3);
            tick(3);
            check("paused", 1, job_paused);
            check("pending", 1, job_pending_out);
            tick(10);
            check("paused", dly != 8'h00, job_paused);
            tick(dly + 8);
            check("paused", 0, job_paused);
            pulse(4);
            tick(3);
            check("marking", 1, marking_in_progress_out);
            pulse(1);
            tick(3);
            check("execution", 0, job_in_execution_out);
            check("marking", 0, marking_in_progress_out);
            check("outputs", v, {job_output_4, job_output_3, job_output_2, job_output_1});
        end
        check("irq", 0, irq);
        axi_rd(ADDR_INT_STATUS, rd, rsp);
        check("int_status", 32'h1 << EV_JOB_DONE, rd);
        axi_wr(ADDR_INT_ENABLE, 32'h1 << EV_JOB_DONE, rsp);
        tick(3);
        check("irq", 1, irq);
        axi_wr(ADDR_INT_CLEAR, 32'h1 << EV_JOB_DONE, rsp);
        tick(3);
        check("irq", 0, irq);
        axi_rd(ADDR_INT_ENABLE, rd, rsp);
        check("int_enable", 32'h1 << EV_JOB_DONE, rd);
        axi_rd(12'h100, rd, rsp);
        check("unmapped_resp", RESP_SLVERR, rsp);
        axi_wr(ADDR_STATUS, 32'hF, rsp);
        check("status_write_resp", RESP_SLVERR, rsp);
        release_delay <= 8'hC8;
        pulse(0);
        tick(3);
        pulse(2);
        tick(4);
        check("paused", 1, job_paused);
        abort_req <= 1'b1;
        tick(3);
        check("pending", 1, job_pending_out);
        abort_req <= 1'b0;
        tick(1);
        check("aborted", 1, job_aborted);
        tick(3);
        check("pending", 0, job_pending_out);
        check("paused", 0, job_paused);
        pulse(0);
        tick(3);
        set_outputs_value <= 4'h6;
        pulse(5);
        tick(3);
        reset_req <= 1'b1;
        tick(8);
        reset_req <= 1'b0;
        tick(3);
        check("pending", 0, job_pending_out);
        check("outputs", 0, {job_output_4, job_output_3, job_output_2, job_output_1});
        check("error_ready", 1, error_ready_out);
        tick(BOOT_CYCLES + 10);
        check("error_ready", 0, error_ready_out);
        pulse(6);
        tick(3);
        check("error_ready", 1, error_ready_out);
        axi_wr(ADDR_CONTROL, 32'h1 << CTRL_EXC_CLR_BIT, rsp);
        tick(3);
        check("error_ready", 0, error_ready_out);
        axi_rd(ADDR_INT_STATUS, rd, rsp);
        check("int_status", 32'h7, rd & 32'h7);
        test_done;
    end
endmodule
`default_nettype wire

// ### hdl/aux_job_io_control.sv
// Auxiliary job-control I/O: isolated inputs, job status outputs and registers
`timescale 1ns/1ps
`default_nettype none
module aux_job_io_control
    import aux_job_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Isolated inputs from outside equipment
    input  wire logic        iso_trigger_input,
    input  wire logic        iso_wait_input_1,
    input  wire logic        iso_wait_input_2,
    input  wire logic        iso_wait_input_3,
    input  wire logic        iso_wait_input_4,
    input  wire logic        iso_reset_request_n,
    input  wire logic        iso_abort_input,
    // Events from the job sequencer
    input  wire logic        job_open_instr,
    input  wire logic        job_close_instr,
    input  wire logic        wait_trigger_instr,
    input  wire logic        wait_input_instr,
    input  wire logic [1:0]  wait_input_select,
    input  wire logic        marking_start,
    input  wire logic        set_outputs_instr,
    input  wire logic [3:0]  set_outputs_value,
    input  wire logic        hw_exception,
    // Status to sequencer and connector
    output var  logic        job_paused,
    output var  logic        job_aborted,
    output var  logic        soft_reset_out,
    output var  logic        error_ready_out,
    output var  logic        job_pending_out,
    output var  logic        job_in_execution_out,
    output var  logic        marking_in_progress_out,
    output var  logic        job_output_1,
    output var  logic        job_output_2,
    output var  logic        job_output_3,
    output var  logic        job_output_4,
    output var  logic        irq,
    // AXI4-Lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    logic [NUM_IN-1:0]     sync_in;
    logic [3:0]            wait_in;
    logic                  trig_s;
    logic                  abort_s;
    logic                  reset_req;
    logic                  soft_rst;
    logic                  run_rst;
    job_state_type         state;
    job_state_type         next_state;
    logic                  wait_on_trigger;
    logic [1:0]            wait_sel;
    logic                  wait_met;
    logic [BOOT_CNT_W-1:0] boot_cnt;
    logic                  booted;
    logic                  exc_latched;
    logic                  sw_exc;
    logic [NUM_EVENTS-1:0] int_status;
    logic [NUM_EVENTS-1:0] int_enable;
    logic [NUM_EVENTS-1:0] events;
    logic [NUM_EVENTS-1:0] clr_mask;
    logic                  exc_clear;
    logic                  aw_held;
    logic                  w_held;
    logic [11:0]           aw_addr;
    logic [31:0]           w_data;
    logic                  wr_fire;
    logic [31:0]           next_rdata;
    logic                  rd_hit;

    iso_input_sync u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({iso_abort_input, iso_reset_request_n, iso_wait_input_4, iso_wait_input_3,
                    iso_wait_input_2, iso_wait_input_1, iso_trigger_input}),
        .sync_out (sync_in)
    );

    assign trig_s    = sync_in[IN_TRIG];
    assign wait_in   = sync_in[IN_WAIT0 +: 4];
    assign abort_s   = sync_in[IN_ABORT];
    assign reset_req = ~sync_in[IN_RESET_N];
    // Soft reset lasts while the request is held; bus registers survive it
    assign run_rst   = !aresetn || reset_req;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= reset_req;
        end
    end

    // Wait release: trigger or the selected general input
    assign wait_met = wait_on_trigger ? trig_s : wait_in[wait_sel];

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (job_open_instr) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_ACTIVE: begin
                if (job_close_instr) begin
                    next_state = ST_IDLE;
                end else if (wait_trigger_instr || wait_input_instr) begin
                    next_state = ST_WAIT;
                end else if (marking_start) begin
                    next_state = ST_MARKING;
                end
            end
            ST_WAIT: begin
                if (wait_met) begin
                    next_state = ST_ACTIVE;
                end
            end
            ST_MARKING: begin
                if (job_close_instr) begin
                    next_state = ST_IDLE;
                end else if (wait_trigger_instr || wait_input_instr) begin
                    next_state = ST_WAIT;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (abort_s) begin
            next_state = ST_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        if (run_rst) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge aclk) begin
        if (run_rst) begin
            wait_on_trigger <= 1'b0;
            wait_sel        <= 2'h0;
        end else if (wait_trigger_instr) begin
            wait_on_trigger <= 1'b1;
        end else if (wait_input_instr) begin
            wait_on_trigger <= 1'b0;
            wait_sel        <= wait_input_select;
        end
    end

    always_ff @(posedge aclk) begin
        if (run_rst) begin
            job_pending_out         <= 1'b0;
            job_in_execution_out    <= 1'b0;
            marking_in_progress_out <= 1'b0;
            job_paused              <= 1'b0;
            job_aborted             <= 1'b0;
        end else begin
            job_pending_out         <= next_state != ST_IDLE;
            job_in_execution_out    <= next_state != ST_IDLE;
            marking_in_progress_out <= next_state == ST_MARKING;
            job_paused              <= next_state == ST_WAIT;
            job_aborted             <= abort_s && state != ST_IDLE;
        end
    end

    always_ff @(posedge aclk) begin
        if (run_rst) begin
            {job_output_4, job_output_3, job_output_2, job_output_1} <= 4'h0;
        end else if (set_outputs_instr) begin
            {job_output_4, job_output_3, job_output_2, job_output_1} <= set_outputs_value;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            soft_reset_out <= 1'b0;
        end else begin
            soft_reset_out <= soft_rst;
        end
    end

    // Boot counter restarts after a soft reset, so ready drops during it
    always_ff @(posedge aclk) begin
        if (run_rst) begin
            boot_cnt <= '0;
            booted   <= 1'b0;
        end else if (boot_cnt == BOOT_CNT_W'(BOOT_CYCLES - 1)) begin
            booted   <= 1'b1;
        end else begin
            boot_cnt <= boot_cnt + BOOT_CNT_W'(1);
        end
    end

    // Exception stays latched until software or a soft reset clears it
    always_ff @(posedge aclk) begin
        if (run_rst) begin
            exc_latched <= 1'b0;
        end else if (hw_exception || sw_exc) begin
            exc_latched <= 1'b1;
        end else if (exc_clear) begin
            exc_latched <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (run_rst) begin
            error_ready_out <= 1'b1;
        end else begin
            error_ready_out <= !booted || exc_latched || hw_exception;
        end
    end

    // AXI4-Lite write path: address and data accepted in either order
    assign wr_fire   = aw_held && w_held && !s_axi_bvalid;
    assign exc_clear = wr_fire && aw_addr == ADDR_CONTROL && w_data[CTRL_EXC_CLR_BIT];
    assign clr_mask  = (wr_fire && aw_addr == ADDR_INT_CLEAR) ? w_data[NUM_EVENTS-1:0] : '0;
    assign events    = {job_close_instr && state != ST_IDLE, hw_exception, reset_req && !soft_rst,
                        abort_s && state != ST_IDLE};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held       <= 1'b1;
                aw_addr       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held       <= 1'b1;
                w_data       <= s_axi_wdata;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr == ADDR_INT_ENABLE || aw_addr == ADDR_INT_CLEAR ||
                                 aw_addr == ADDR_CONTROL) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                aw_held       <= 1'b0;
                w_held        <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Byte strobes ignored: every field sits in the low byte
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_enable <= '0;
            sw_exc     <= 1'b0;
        end else begin
            sw_exc <= wr_fire && aw_addr == ADDR_CONTROL && w_data[CTRL_EXC_BIT];
            if (wr_fire && aw_addr == ADDR_INT_ENABLE) begin
                int_enable <= w_data[NUM_EVENTS-1:0];
            end
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_status <= '0;
        end else begin
            int_status <= (int_status & ~clr_mask) | events;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(((int_status & ~clr_mask) | events) & int_enable);
        end
    end

    // AXI4-Lite read path
    always_comb begin
        next_rdata = '0;
        rd_hit     = 1'b1;
        unique case (s_axi_araddr)
            ADDR_STATUS:     next_rdata = {22'h0, wait_sel, state, exc_latched, booted,
                                           marking_in_progress_out, job_pending_out};
            ADDR_INT_STATUS: next_rdata = {28'h0, int_status};
            ADDR_INT_ENABLE: next_rdata = {28'h0, int_enable};
            ADDR_CONTROL:    next_rdata = {31'h0, exc_latched};
            default:         rd_hit     = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ### hdl/aux_job_pkg.sv
// Constants shared by the auxiliary job-control I/O block
// How it works
// - A wait-for-trigger instruction holds the job paused until the isolated trigger input is high.
// - A wait instruction can pause the job until any chosen one of the four isolated wait inputs is high.
// - A low level on the isolated reset request input soft-resets the job, output, boot and exception state; bus registers keep their values.
// - The isolated abort input ends the current job and returns the job logic to idle.
// - The error/ready output goes low once boot is finished and the block is ready.
// - The error/ready output is high from power-up until ready and again after a hardware exception.
// - The job-pending output is high whenever a job is active, even while it waits before marking.
// - The job-in-execution output is set by a job-open instruction and cleared by a job-close instruction given outside a wait.
// - The marking-in-progress output is high while marking and drops on a job-close instruction.
// - Each general-purpose output takes the level a set-outputs instruction writes and holds it until rewritten or cleared by a soft reset.
package aux_job_pkg;
    localparam int          BOOT_TIME_NS     = 1000;
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          BOOT_CYCLES      = (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          BOOT_CNT_W       = 8;
    localparam int          NUM_IN           = 7;
    localparam int          IN_TRIG          = 0;
    localparam int          IN_WAIT0         = 1;
    localparam int          IN_RESET_N       = 5;
    localparam int          IN_ABORT         = 6;
    localparam logic [6:0]  SYNC_RESET_VALUE = 7'h20;

    localparam logic [11:0] ADDR_STATUS      = 12'h000;
    localparam logic [11:0] ADDR_INT_STATUS  = 12'h004;
    localparam logic [11:0] ADDR_INT_ENABLE  = 12'h008;
    localparam logic [11:0] ADDR_INT_CLEAR   = 12'h00C;
    localparam logic [11:0] ADDR_CONTROL     = 12'h010;
    localparam int          NUM_EVENTS       = 4;
    localparam int          EV_ABORT         = 0;
    localparam int          EV_SOFT_RESET    = 1;
    localparam int          EV_EXCEPTION     = 2;
    localparam int          EV_JOB_DONE      = 3;
    localparam int          CTRL_EXC_BIT     = 0;
    localparam int          CTRL_EXC_CLR_BIT = 1;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'h1,
        ST_ACTIVE  = 4'h2,
        ST_WAIT    = 4'h4,
        ST_MARKING = 4'h8
    } job_state_type;
endpackage

// ### hdl/iso_input_sync.sv
// Two-stage synchroniser bank for the isolated inputs
`timescale 1ns/1ps
`default_nettype none
module iso_input_sync
    import aux_job_pkg::*;
(
    input  wire logic                aclk,
    input  wire logic                aresetn,
    input  wire logic [NUM_IN-1:0]   async_in,
    output var  logic [NUM_IN-1:0]   sync_out
);
    logic [NUM_IN-1:0] stage1;

    // First stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1   <= SYNC_RESET_VALUE;
            sync_out <= SYNC_RESET_VALUE;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule
`default_nettype wire
